/* File: shared/ros_pkg.sv */
package ros_pkg;
  // Configuration codes and reset values
  localparam logic [7:0] ROS_SRC_RESET = 8'h05;
  localparam logic [7:0] ROS_SENSE_RESET = 8'h01;
  localparam logic [7:0] ROS_SENSE_MAKE_ON_COND = 8'h00;
  localparam logic [7:0] ROS_SENSE_MAKE_ON_POWER = 8'h01;
  localparam logic [7:0] ROS_SRC_MAX_LOW = 8'h0D;
  localparam logic [7:0] ROS_SRC_MIN_HIGH = 8'h13;
  localparam logic [7:0] ROS_SRC_MAX_HIGH = 8'h1A;
  // Register select on the configuration port
  localparam logic ROS_REG_SOURCE = 1'b0;
  localparam logic ROS_REG_SENSE = 1'b1;
  // Power-on hold of the break position
  localparam int ROS_CLK_PERIOD_NS = 100;
  localparam int ROS_POWERON_HOLD_NS = 1000000;
  localparam int ROS_POWERON_HOLD_CYC =
    (ROS_POWERON_HOLD_NS + ROS_CLK_PERIOD_NS - 1) / ROS_CLK_PERIOD_NS;
  localparam int ROS_HIST_DEPTH = 4;

  // Status conditions, one bit each, named by source code
  typedef struct packed {
    logic overload_alarm_second;  // 26
    logic freq_arrival_level2;    // 25
    logic freq_over_level2;       // 24
    logic position_done;          // 23
    logic speed_deviation;        // 22
    logic zero_speed;             // 21
    logic brake_error;            // 20
    logic brake_release;          // 19
    logic motor_thermal_warning;  // 13
    logic power_time_expired;     // 12
    logic run_time_expired;       // 11
    logic torque_limiting;        // 10
    logic supply_low;             // 09
    logic mains_loss_stop;        // 08
    logic torque_over;            // 07
    logic freq_in_band;           // 06
    logic trip_indicator;         // 05
    logic pid_deviation_alarm;    // 04
    logic overload_alarm;         // 03
    logic freq_over;              // 02
    logic freq_arrival;           // 01
    logic running;                // 00
  } ros_cond_t;

  // Configuration write request
  typedef struct packed {
    logic wr_en;
    logic reg_sel;
    logic [7:0] wdata;
  } ros_cfg_wr_t;

  // Fault record written into the history
  typedef struct packed {
    logic valid;
    logic [7:0] code;
  } ros_fault_t;
endpackage

/* File: hdl/ros_relay_output_select.sv */
`timescale 1ns/1ps
module ros_relay_output_select #(
  parameter int HOLD_CYCLES = ros_pkg::ROS_POWERON_HOLD_CYC,
  parameter int HIST_DEPTH = ros_pkg::ROS_HIST_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Supply state
  input wire logic power_good,
  // Status conditions
  input wire ros_pkg::ros_cond_t cond,
  // Configuration port
  input wire ros_pkg::ros_cfg_wr_t cfg_wr,
  output logic [7:0] relay_source_select,
  output logic [7:0] relay_sense_select,
  output logic cfg_reject,
  // Fault history
  input wire ros_pkg::ros_fault_t fault_in,
  input wire logic nv_init,
  input wire logic [$clog2(HIST_DEPTH)-1:0] hist_rd_idx,
  output logic [7:0] hist_rd_data,
  output logic [7:0] hist_count,
  // Relay contacts
  output logic relay_make_contact,
  output logic relay_break_contact
);

  localparam int CW = $clog2(HOLD_CYCLES + 1);
  localparam int IW = $clog2(HIST_DEPTH);

  // Parameters the counters and history cannot serve
  if (HOLD_CYCLES < 1 || HIST_DEPTH < 2 || HIST_DEPTH > 255)
  begin : g_bad_param
    $error("ros_relay_output_select: parameter out of range");
  end

  typedef enum logic [1:0] {ROS_OFF, ROS_HOLD, ROS_RUN} ros_state_t;

  ros_state_t state_q, state_d;
  logic [CW-1:0] hold_cnt_q, hold_cnt_d;
  logic [7:0] src_q, src_d;
  logic [7:0] sense_q, sense_d;
  logic reject_q, reject_d;
  logic make_q, make_d;
  logic break_q, break_d;
  logic [7:0] rd_q;
  logic [7:0] cnt_q, cnt_d;
  logic [7:0] hist_mem [HIST_DEPTH];

  // Condition multiplexer
  function automatic logic pick(input ros_pkg::ros_cond_t c, input logic [7:0] code);
    logic r;
    r = 1'b0;
    case (code)
      8'h00: r = c.running;
      8'h01: r = c.freq_arrival;
      8'h02: r = c.freq_over;
      8'h03: r = c.overload_alarm;
      8'h04: r = c.pid_deviation_alarm;
      8'h05: r = c.trip_indicator;
      8'h06: r = c.freq_in_band;
      8'h07: r = c.torque_over;
      8'h08: r = c.mains_loss_stop;
      8'h09: r = c.supply_low;
      8'h0A: r = c.torque_limiting;
      8'h0B: r = c.run_time_expired;
      8'h0C: r = c.power_time_expired;
      8'h0D: r = c.motor_thermal_warning;
      8'h13: r = c.brake_release;
      8'h14: r = c.brake_error;
      8'h15: r = c.zero_speed;
      8'h16: r = c.speed_deviation;
      8'h17: r = c.position_done;
      8'h18: r = c.freq_over_level2;
      8'h19: r = c.freq_arrival_level2;
      8'h1A: r = c.overload_alarm_second;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  wire sel_cond = pick(cond, src_q);

  wire src_legal = (cfg_wr.wdata <= ros_pkg::ROS_SRC_MAX_LOW) ||
                   (cfg_wr.wdata >= ros_pkg::ROS_SRC_MIN_HIGH &&
                    cfg_wr.wdata <= ros_pkg::ROS_SRC_MAX_HIGH);
  wire sense_legal = (cfg_wr.wdata == ros_pkg::ROS_SENSE_MAKE_ON_COND) ||
                     (cfg_wr.wdata == ros_pkg::ROS_SENSE_MAKE_ON_POWER);
  wire wr_src = cfg_wr.wr_en && cfg_wr.reg_sel == ros_pkg::ROS_REG_SOURCE;
  wire wr_sense = cfg_wr.wr_en && cfg_wr.reg_sel == ros_pkg::ROS_REG_SENSE;

  assign src_d = (wr_src && src_legal) ? cfg_wr.wdata : src_q;
  assign sense_d = (wr_sense && sense_legal) ? cfg_wr.wdata : sense_q;
  assign reject_d = (wr_src && !src_legal) || (wr_sense && !sense_legal);

  wire make_on = (sense_q == ros_pkg::ROS_SENSE_MAKE_ON_POWER) ? !sel_cond : sel_cond;
  wire hold_done = hold_cnt_q == CW'(HOLD_CYCLES);

  always_comb
  begin
    state_d = state_q;
    hold_cnt_d = hold_cnt_q;
    unique case (state_q)
      ROS_OFF:
      begin
        hold_cnt_d = '0;
        if (power_good)
          state_d = ROS_HOLD;
      end
      ROS_HOLD:
      begin
        hold_cnt_d = hold_cnt_q + CW'(1);
        if (!power_good)
          state_d = ROS_OFF;
        else if (hold_done)
          state_d = ROS_RUN;
      end
      ROS_RUN:
      begin
        if (!power_good)
          state_d = ROS_OFF;
      end
    endcase
  end

  assign make_d = (state_d == ROS_RUN) ? make_on : 1'b0;
  assign break_d = (state_d == ROS_RUN) ? !make_on : 1'b1;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= ROS_OFF;
      hold_cnt_q <= '0;
      src_q <= ros_pkg::ROS_SRC_RESET;
      sense_q <= ros_pkg::ROS_SENSE_RESET;
      reject_q <= 1'b0;
      make_q <= 1'b0;
      break_q <= 1'b1;
      rd_q <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      hold_cnt_q <= hold_cnt_d;
      src_q <= src_d;
      sense_q <= sense_d;
      reject_q <= reject_d;
      make_q <= make_d;
      break_q <= break_d;
      rd_q <= hist_mem[hist_rd_idx];
    end
  end

  assign cnt_d = nv_init ? 8'h00 :
                 (fault_in.valid && cnt_q != 8'(HIST_DEPTH)) ? cnt_q + 8'h01 : cnt_q;

  always_ff @(posedge clk)
  begin
    cnt_q <= cnt_d;
  end

  genvar gi;
  generate
    for (gi = 0; gi < HIST_DEPTH; gi++)
    begin : g_hist
      always_ff @(posedge clk)
      begin
        if (nv_init)
          hist_mem[gi] <= 8'h00;
        else if (fault_in.valid)
          hist_mem[gi] <= (gi == 0) ? fault_in.code : hist_mem[(gi == 0) ? 0 : gi - 1];
      end
    end
  endgenerate

  assign relay_source_select = src_q;
  assign relay_sense_select = sense_q;
  assign cfg_reject = reject_q;
  assign hist_rd_data = rd_q;
  assign hist_count = cnt_q;
  assign relay_make_contact = make_q;
  assign relay_break_contact = break_q;

  // Helper: cycles spent holding
  logic [CW-1:0] seen_q;
  always_ff @(posedge clk)
  begin
    if (rst || !power_good)
      seen_q <= '0;
    else if (seen_q != CW'(HOLD_CYCLES))
      seen_q <= seen_q + CW'(1);
  end

  AST_RESET_SOURCE:
  assert property (@(posedge clk) $past(rst) |-> relay_source_select == ros_pkg::ROS_SRC_RESET &&
                   relay_sense_select == ros_pkg::ROS_SENSE_RESET)
    else $error("Reset selection wrong");

  AST_CODE_TRIP:
  assert property (@(posedge clk) disable iff (rst)
                   state_q == ROS_RUN && $stable(state_q) && src_q == 8'h05 && sense_q == 8'h00 &&
                   power_good
                   |=> relay_make_contact == $past(cond.trip_indicator))
    else $error("Code 05 not selecting trip");

  AST_CODE_THERMAL:
  assert property (@(posedge clk) disable iff (rst)
                   state_q == ROS_RUN && src_q == 8'h0D && sense_q == 8'h00 && power_good
                   |=> relay_make_contact == $past(cond.motor_thermal_warning))
    else $error("Code 13 not selecting thermal");

  AST_CODE_OVERLOAD2:
  assert property (@(posedge clk) disable iff (rst)
                   state_q == ROS_RUN && src_q == 8'h1A && sense_q == 8'h01 && power_good
                   |=> relay_make_contact == !$past(cond.overload_alarm_second))
    else $error("Code 26 not selecting overload 2");

  AST_SENSE_COMPL:
  assert property (@(posedge clk) disable iff (rst)
                   relay_make_contact |-> !relay_break_contact)
    else $error("Both pairs closed");

  AST_POWER_OFF:
  assert property (@(posedge clk) disable iff (rst)
                   !power_good |=> relay_break_contact && !relay_make_contact)
    else $error("Power off not in break position");

  AST_HOLD_TIME:
  assert property (@(posedge clk) disable iff (rst)
                   relay_make_contact |-> seen_q == CW'(HOLD_CYCLES))
    else $error("Make closed before hold elapsed");

  AST_REJECT_KEEP:
  assert property (@(posedge clk) disable iff (rst)
                   wr_src && !src_legal |=> cfg_reject && $stable(relay_source_select))
    else $error("Reserved code accepted");

  AST_HIST_WRITE:
  assert property (@(posedge clk) disable iff (rst)
                   fault_in.valid && !nv_init |=> hist_mem[0] == $past(fault_in.code))
    else $error("Fault code not stored");

endmodule

/* File: bench/ros_ext_equipment.sv */
`timescale 1ns/1ps
// Equipment on the changeover contacts, alarm lamp fed from the break pair
module ros_ext_equipment (
  // Contacts
  input wire logic relay_make_contact,
  input wire logic relay_break_contact,
  // Equipment view
  output logic lamp_on
);
  // A contact clash leaves the lamp dark
  assign lamp_on = relay_break_contact & ~relay_make_contact;
endmodule

/* File: bench/tb_relay_output_select.sv */
`timescale 1ns/1ps
module tb_relay_output_select;
  logic clk;
  logic rst;
  logic power_good;
  ros_pkg::ros_cond_t cond;
  ros_pkg::ros_cfg_wr_t cfg_wr;
  ros_pkg::ros_fault_t fault_in;
  logic nv_init;
  logic [1:0] idx;
  logic [7:0] src_q, sense_q, rd_data, count;
  logic reject, make_c, break_c, lamp_on;
  int failures, n_compared, m_src, m_sense;
  int hist[$];

  ros_relay_output_select #(.HOLD_CYCLES(5), .HIST_DEPTH(4)) u_dut (.clk(clk), .rst(rst),
    .power_good(power_good), .cond(cond), .cfg_wr(cfg_wr), .relay_source_select(src_q),
    .relay_sense_select(sense_q), .cfg_reject(reject), .fault_in(fault_in), .nv_init(nv_init),
    .hist_rd_idx(idx), .hist_rd_data(rd_data), .hist_count(count),
    .relay_make_contact(make_c), .relay_break_contact(break_c));
  ros_ext_equipment u_ext (.relay_make_contact(make_c), .relay_break_contact(break_c),
    .lamp_on(lamp_on));

  initial
  begin
    clk = 0;
    forever #50 clk = ~clk;
  end

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Model of the contacts from live condition, source and sense
  task automatic chk_relay(input string what);
    logic c;
    logic mk;
    c = cond[(m_src <= 13) ? m_src : m_src - 5];
    mk = power_good && ((m_sense == 1) ? !c : c);
    chk_bit(make_c, mk, what);
    chk_bit(break_c, !mk, what);
    chk_bit(lamp_on, !mk, what);
  endtask

  task automatic wr(input logic sel, input int val);
    logic ok;
    ok = sel ? (val <= 1) : (val <= 13 || (val >= 19 && val <= 26));
    cfg_wr = {1'b1, sel, 8'(val)};
    cyc(1);
    cfg_wr.wr_en = 1'b0;
    chk_bit(reject, !ok, "reject");
    if (ok && sel)
      m_sense = val;
    else if (ok)
      m_src = val;
    cyc(1);
    chk_reg(sel ? sense_q : src_q, 8'(sel ? m_sense : m_src), "register");
  endtask

  task automatic wrap_up();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    #2ms;
    failures++;
    $display("BAD %0t run did not finish", $time);
    wrap_up();
  end

  initial
  begin
    void'($urandom(32'h0561c00b));
    rst = 1;
    power_good = 0;
    cond = '0;
    cfg_wr = '0;
    fault_in = '0;
    nv_init = 1;
    idx = '0;
    failures = 0;
    n_compared = 0;
    m_src = 5;
    m_sense = 1;
    cyc(6);
    rst = 0;
    nv_init = 0;
    chk_reg(src_q, 8'h05, "source reset");
    chk_reg(sense_q, 8'h01, "sense reset");
    chk_relay("off");
    power_good = 1;
    cyc(3);
    chk_bit(make_c, 1'b0, "hold make");
    chk_bit(lamp_on, 1'b1, "hold break");
    cyc(3);
    chk_bit(make_c, 1'b0, "hold end make");
    chk_bit(break_c, 1'b1, "hold end break");
    cyc(1);
    chk_relay("normal");
    cond.trip_indicator = 1'b1;
    cyc(2);
    chk_relay("fault");
    $display("test power_on done");
    for (int v = 0; v <= 27; v++)
    begin
      wr(1'b0, v);
      for (int s = 0; s < 2; s++)
      begin
        wr(1'b1, s);
        cond = 22'($urandom);
        cyc(2);
        chk_relay("random");
        cond = ~cond;
        cyc(2);
        chk_relay("inverse");
      end
    end
    wr(1'b1, 2);
    wr(1'b0, 255);
    $display("test select done");
    wr(1'b1, 0);
    power_good = 0;
    cyc(2);
    chk_relay("off sense 00");
    $display("test power_off done");
    for (int k = 0; k < 5; k++)
    begin
      fault_in = {1'b1, 8'($urandom_range(79, 1))};
      hist.push_front(int'(fault_in.code));
      cyc(1);
    end
    fault_in.valid = 1'b0;
    rst = 1;
    cyc(2);
    rst = 0;
    chk_reg(src_q, 8'h05, "source reset again");
    chk_reg(sense_q, 8'h01, "sense reset again");
    m_src = 5;
    m_sense = 1;
    power_good = 1;
    cond = '0;
    cyc(10);
    chk_relay("power return");
    chk_reg(count, 8'h04, "count");
    for (int i = 0; i < 4; i++)
    begin
      idx = 2'(i);
      cyc(2);
      chk_reg(rd_data, 8'(hist[i]), "history");
    end
    $display("test history done");
    wrap_up();
  end
endmodule
